// ### rtcis_params.svh
// Purpose: constants of the serial-bus master that talks to the real-time clock slave.
// Assumes: 10 MHz system clock; the slave answers at a fixed 7-bit address.
// Notes: the master makes the serial clock itself from the system clock.
`ifndef RTCIS_PARAMS_SVH
`define RTCIS_PARAMS_SVH

`define RTCIS_BYTE_W 8
`define RTCIS_SLAVE_ADDR 7'h68
`define RTCIS_DIR_RD 1'b1
`define RTCIS_ACK_BIT 4'h8
`define RTCIS_FIFO_DEPTH 8
`define RTCIS_CLK_PERIOD_NS 100
`define RTCIS_SCL_STD_PERIOD_NS 10000
`define RTCIS_SCL_FAST_PERIOD_NS 2500
// a quarter of the bus period, rounded up so the bus is never faster than allowed
`define RTCIS_QTR_CYC(p) (((p) + 4 * `RTCIS_CLK_PERIOD_NS - 1) / (4 * `RTCIS_CLK_PERIOD_NS))

`endif

// ### rtcis_pkg.sv
// Purpose: types shared by the serial-bus master and its test bench.
// Assumes: constants come from rtcis_params.svh.
// Notes: none.
`include "rtcis_params.svh"

package rtcis_pkg;

  typedef logic [`RTCIS_BYTE_W-1:0] rtcis_byte_t;

  // one transfer request: optional pointer write, then len bytes written, or len bytes read with at least one
  typedef struct packed {
    logic rd;
    logic set_ptr;
    rtcis_byte_t ptr;
    rtcis_byte_t len;
  } rtcis_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_START_B, S_BIT_LOW, S_BIT_HIGH, S_BIT_WAIT, S_BIT_FALL,
    S_FETCH, S_STOP_A, S_STOP_B, S_STOP_C, S_RS_A, S_RS_B, S_RS_C
  } rtcis_state_t;

  typedef enum logic [2:0] {
    P_ADDR_W, P_PTR, P_WDATA, P_ADDR_R, P_RDATA
  } rtcis_step_t;

endpackage

// ### rtcis_fifo.sv
// Purpose: small buffer between the user's write bytes and the bus engine.
// Assumes: one clock; depth is a power of two.
// Notes: head word and both ready/valid flags come straight from registers.
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_params.svh"

module rtcis_fifo #(
  parameter int W = `RTCIS_BYTE_W,
  parameter int DEPTH = `RTCIS_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic in_ready, out_valid, next_in_ready, next_out_valid;
  logic [W-1:0] head, next_head;
  logic push, pop;

  always_comb begin
    push = in_valid_i && in_ready;
    pop = out_valid && out_ready_i;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_in_ready = next_count != (AW+1)'(DEPTH);
    next_out_valid = next_count != '0;
    // bypass: a word written this cycle into the head slot is not yet in mem
    next_head = (push && wr_ptr == next_rd_ptr) ? in_data_i : mem[next_rd_ptr];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      head <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      head <= next_head;
    end
  end

  // storage has no reset on purpose: only the pointers matter
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = in_ready;
  assign out_valid_o = out_valid;
  assign out_data_o = head;

endmodule

`default_nettype wire

// ### rtcis_master.sv
// Purpose: serial-bus master that writes and reads the clock slave's registers.
// Assumes: open-drain SCL/SDA with external pull-ups; oe high pulls the line low.
// Notes: waits while the slave stretches SCL; a stalled write buffer holds SCL low.
`timescale 1ns/100ps
`default_nettype none
`include "rtcis_params.svh"

module rtcis_master
  import rtcis_pkg::*;
#(
  parameter int QTR_CYC = `RTCIS_QTR_CYC(`RTCIS_SCL_STD_PERIOD_NS)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire rtcis_cmd_t cmd_i,
  output logic cmd_ready_o,
  input wire logic wr_valid_i,
  input wire rtcis_byte_t wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output rtcis_byte_t rd_data_o,
  output logic done_o,
  output logic err_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam logic [7:0] QTR_M1 = 8'(QTR_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and quarter-period enable

  logic scl_m, scl_s, sda_m, sda_s;
  logic [7:0] qcnt, next_qcnt;
  logic tick;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      sda_m <= sda_i;
      sda_s <= sda_m;
    end
  end

  always_comb begin
    tick = qcnt == 8'h00;
    next_qcnt = tick ? QTR_M1 : qcnt - 8'h01;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= next_qcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write buffer

  logic fifo_valid, fifo_pop;
  rtcis_byte_t fifo_data;

  rtcis_fifo #(
    .W(`RTCIS_BYTE_W),
    .DEPTH(`RTCIS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus engine

  rtcis_state_t st, next_st;
  rtcis_step_t step, next_step;
  rtcis_cmd_t cmd, next_cmd;
  rtcis_byte_t shreg, next_shreg, len_left, next_len, rd_data, next_rd_data;
  logic [3:0] bitn, next_bitn;
  logic ack_bit, next_ack, scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic rd_valid, next_rd_valid, done, next_done, err, next_err;
  logic cmd_ready, next_cmd_ready, rx;

  always_comb begin
    next_st = st;
    next_step = step;
    next_cmd = cmd;
    next_shreg = shreg;
    next_len = len_left;
    next_rd_data = rd_data;
    next_bitn = bitn;
    next_ack = ack_bit;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    next_err = err;
    fifo_pop = 1'b0;
    rx = step == P_RDATA;
    case (st)
      S_IDLE: begin
        if (cmd_valid_i && cmd_ready) begin
          next_cmd = cmd_i;
          next_len = cmd_i.len;
          next_err = 1'b0;
          // no pointer write means the slave reads from its kept pointer
          next_step = (cmd_i.set_ptr || !cmd_i.rd) ? P_ADDR_W : P_ADDR_R;
          next_st = S_START;
        end
      end
      S_START: begin
        if (tick) begin
          next_sda_oe = 1'b1;
          next_st = S_START_B;
        end
      end
      S_START_B: begin
        if (tick) begin
          next_scl_oe = 1'b1;
          next_shreg = {`RTCIS_SLAVE_ADDR, step == P_ADDR_R};
          next_bitn = 4'h0;
          next_st = S_BIT_LOW;
        end
      end
      S_BIT_LOW: begin
        if (tick) begin
          if (bitn == `RTCIS_ACK_BIT) begin
            next_sda_oe = rx && (len_left > 8'h01);
          end else begin
            next_sda_oe = !rx && !shreg[7];
          end
          next_st = S_BIT_HIGH;
        end
      end
      S_BIT_HIGH: begin
        if (tick) begin
          next_scl_oe = 1'b0;
          next_st = S_BIT_WAIT;
        end
      end
      S_BIT_WAIT: begin
        // stretched clock: sample only once the line is really high
        if (tick && scl_s) begin
          if (bitn == `RTCIS_ACK_BIT) begin
            next_ack = sda_s;
          end else begin
            next_shreg = {shreg[6:0], sda_s};
          end
          next_st = S_BIT_FALL;
        end
      end
      S_BIT_FALL: begin
        if (tick) begin
          next_scl_oe = 1'b1;
          next_st = S_BIT_LOW;
          if (bitn != `RTCIS_ACK_BIT) begin
            next_bitn = bitn + 4'h1;
          end else begin
            next_bitn = 4'h0;
            if (rx) begin
              next_rd_data = shreg;
              next_rd_valid = 1'b1;
              next_len = len_left - 8'h01;
              if (len_left <= 8'h01) begin
                next_st = S_STOP_A;
              end
            end else if (ack_bit) begin
              next_err = 1'b1;
              next_st = S_STOP_A;
            end else begin
              case (step)
                P_ADDR_W: begin
                  if (cmd.set_ptr) begin
                    next_step = P_PTR;
                    next_shreg = cmd.ptr;
                  end else if (len_left != 8'h00) begin
                    next_step = P_WDATA;
                    next_st = S_FETCH;
                  end else begin
                    next_st = S_STOP_A;
                  end
                end
                P_PTR: begin
                  if (cmd.rd) begin
                    next_step = P_ADDR_R;
                    next_st = S_RS_A;
                  end else if (len_left != 8'h00) begin
                    next_step = P_WDATA;
                    next_st = S_FETCH;
                  end else begin
                    next_st = S_STOP_A;
                  end
                end
                P_WDATA: begin
                  next_len = len_left - 8'h01;
                  next_st = (len_left == 8'h01) ? S_STOP_A : S_FETCH;
                end
                P_ADDR_R: begin
                  next_step = P_RDATA;
                end
                default: begin
                  next_st = S_STOP_A;
                end
              endcase
            end
          end
        end
      end
      S_FETCH: begin
        // SCL stays low until the user supplies the next byte
        if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_shreg = fifo_data;
          next_st = S_BIT_LOW;
        end
      end
      S_STOP_A: begin
        if (tick) begin
          next_sda_oe = 1'b1;
          next_st = S_STOP_B;
        end
      end
      S_STOP_B: begin
        if (tick) begin
          next_scl_oe = 1'b0;
          next_st = S_STOP_C;
        end
      end
      S_STOP_C: begin
        if (tick && scl_s) begin
          next_sda_oe = 1'b0;
          next_done = 1'b1;
          next_st = S_IDLE;
        end
      end
      S_RS_A: begin
        if (tick) begin
          next_sda_oe = 1'b0;
          next_st = S_RS_B;
        end
      end
      S_RS_B: begin
        if (tick) begin
          next_scl_oe = 1'b0;
          next_st = S_RS_C;
        end
      end
      S_RS_C: begin
        if (tick && scl_s) begin
          next_st = S_START;
        end
      end
      default: begin
        next_st = S_IDLE;
      end
    endcase
    next_cmd_ready = (next_st == S_IDLE) && scl_s && sda_s;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= S_IDLE;
      step <= P_ADDR_W;
      cmd <= '0;
      shreg <= 8'h00;
      len_left <= 8'h00;
      rd_data <= 8'h00;
      bitn <= 4'h0;
      ack_bit <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      st <= next_st;
      step <= next_step;
      cmd <= next_cmd;
      shreg <= next_shreg;
      len_left <= next_len;
      rd_data <= next_rd_data;
      bitn <= next_bitn;
      ack_bit <= next_ack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      rd_valid <= next_rd_valid;
      done <= next_done;
      err <= next_err;
      cmd_ready <= next_cmd_ready;
    end
  end

  assign cmd_ready_o = cmd_ready;
  assign rd_valid_o = rd_valid;
  assign rd_data_o = rd_data;
  assign done_o = done;
  assign err_o = err;
  assign scl_oe_o = scl_oe;
  assign sda_oe_o = sda_oe;
  // open drain: the driven level is always low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_start_go;
    st == S_START && tick;
  endsequence
  sequence s_nack_seen;
    st == S_BIT_FALL && tick && bitn == `RTCIS_ACK_BIT && step != P_RDATA && ack_bit;
  endsequence
  sequence s_stop_edge;
    st == S_STOP_C && tick && scl_s;
  endsequence

  a_bus_idle_start: assert property (
    $rose(st != S_IDLE) |-> $past(scl_s && sda_s, 2))
    else $error("transfer began on a busy bus");
  a_start_shape: assert property (
    s_start_go |=> sda_oe && !scl_oe ##[1:QTR_CYC] scl_oe)
    else $error("start condition malformed");
  a_stop_shape: assert property (
    s_stop_edge |=> !sda_oe && !scl_oe && done)
    else $error("stop condition malformed");
  a_sda_in_low: assert property (
    $changed(sda_oe) && !($past(st) inside {S_START, S_STOP_C}) |-> scl_oe && $past(scl_oe))
    else $error("data changed while clock high");
  a_scl_release: assert property (
    $fell(scl_oe) |-> $past(st) inside {S_BIT_HIGH, S_STOP_B, S_RS_B})
    else $error("stray clock pulse");
  a_ack_drive: assert property (
    st == S_BIT_WAIT && rx && bitn == `RTCIS_ACK_BIT && len_left > 8'h01 |-> sda_oe)
    else $error("read byte not acknowledged");
  a_last_nack: assert property (
    st == S_BIT_WAIT && rx && bitn == `RTCIS_ACK_BIT && len_left <= 8'h01 |-> !sda_oe)
    else $error("last read byte acknowledged");
  a_addr_byte: assert property (
    st == S_START_B && tick |=> shreg == {`RTCIS_SLAVE_ADDR, step == P_ADDR_R})
    else $error("wrong address byte");
  a_nack_abort: assert property (
    s_nack_seen |=> st == S_STOP_A && err)
    else $error("not-acknowledge did not end the transfer");
  a_rstart_addr: assert property (
    st == S_RS_C && tick && scl_s |=> st == S_START && step == P_ADDR_R)
    else $error("repeated start not followed by read address");

endmodule

`default_nettype wire

// ### rtcis_slave_model.sv
// Purpose: behavioural clock slave at the far end of the serial bus
// Assumes: both lines are wired-and with pull-ups
// Notes: stretch_i holds SCL low after each ack to act slowly
`timescale 1ns/100ps
`default_nettype none

module rtcis_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] addr_i,
  input wire logic stretch_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  logic [7:0] mem [256];
  logic [7:0] ptr, sh;
  logic act, tx, adr, first, ackd;
  int cnt;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7) ^ 8'h3c;
    ptr = 8'h00;
    sh = 8'h00;
    {act, tx, adr, first, ackd} = 5'h00;
    cnt = 0;
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions only count while the clock line is high
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    {act, tx, adr, first} = 4'hb;
    cnt = 0;
    sda_oe_o = 1'b0;
  end

  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b0;
    sda_oe_o = 1'b0;
  end

  always @(posedge scl_i) if (act) begin
    if (cnt < 8 && !tx) sh = {sh[6:0], sda_i};
    if (cnt == 8) ackd = !sda_i;
    cnt++;
  end

  // all data drive changes happen at the falling clock edge; start and stop only release SDA
  always @(negedge scl_i) if (act) begin
    if (cnt == 8) begin
      if (tx) sda_oe_o = 1'b0;
      else if (adr && sh[7:1] != addr_i) act = 1'b0;
      else begin
        sda_oe_o = 1'b1;
        if (adr) tx = sh[0];
        else if (first) begin
          ptr = sh;
          first = 1'b0;
        end else begin
          mem[ptr] = sh;
          ptr++;
        end
      end
    end else if (cnt == 9) begin
      cnt = 0;
      sda_oe_o = 1'b0;
      if (tx && !(adr || ackd)) act = 1'b0;
      else if (tx) begin
        sh = mem[ptr];
        ptr++;
        sda_oe_o = !sh[7];
      end
      adr = 1'b0;
      if (stretch_i) begin
        scl_oe_o = 1'b1;
        #1000;
        scl_oe_o = 1'b0;
      end
    end else if (tx && cnt > 0) sda_oe_o = !sh[7 - cnt];
  end
endmodule
`default_nettype wire

// ### test_rtcis_master.sv
// Purpose: self-checking bench of the serial-bus master
// Assumes: slave model preloaded with the same pattern as exp_mem
// Notes: a quarter period of 2 clocks plus the wait for the synchronised SCL gives a 1000 ns bus clock
`timescale 1ns/100ps
`default_nettype none

module test_rtcis_master
  import rtcis_pkg::*;
;
  logic clk, arst_n, cmd_valid, wr_valid, stretch;
  logic cmd_ready, wr_ready, rd_valid, done, err;
  logic m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, m_scl_o, m_sda_o;
  logic [6:0] s_addr;
  rtcis_cmd_t cmd;
  rtcis_byte_t wr_data, rd_data, exp_ptr;
  rtcis_byte_t exp_mem [256];
  rtcis_byte_t wrq [$], sent [$], rxq [$];
  int n_errors, checked, cyc, n_len;
  wire scl_w = !(m_scl_oe | s_scl_oe);
  wire sda_w = !(m_sda_oe | s_sda_oe);

  rtcis_master #(.QTR_CYC(2)) rtcis_master_i (
    .clk_i(clk), .arst_n_i(arst_n), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
    .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .err_o(err), .scl_i(scl_w), .scl_o(m_scl_o), .scl_oe_o(m_scl_oe),
    .sda_i(sda_w), .sda_o(m_sda_o), .sda_oe_o(m_sda_oe));

  rtcis_slave_model rtcis_slave_model_i (.scl_i(scl_w), .sda_i(sda_w), .addr_i(s_addr),
    .stretch_i(stretch), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_sim();
    end
  end

  always @(negedge clk) if (rd_valid === 1'b1) rxq.push_back(rd_data);

  // feeder holds each byte until a rising edge sees ready
  initial begin
    wr_valid = 1'b0;
    wr_data = 8'h00;
    forever begin
      @(negedge clk);
      wr_valid = wrq.size() > 0;
      if (wr_valid) begin
        wr_data = wrq[0];
        do @(posedge clk); while (wr_ready !== 1'b1);
        void'(wrq.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a read of length zero still moves one byte; a refused address moves none
  function automatic rtcis_byte_t exp_reads(logic nak, rtcis_byte_t n);
    return nak ? 8'h00 : (n == 8'h00) ? 8'h01 : n;
  endfunction

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fill(int n);
    repeat (n) begin
      sent.push_back(8'($urandom));
      wrq.push_back(sent[$]);
    end
  endtask

  task automatic xfer(string name, logic rd, logic sp, rtcis_byte_t p, rtcis_byte_t n, logic nak);
    int k;
    rxq = {};
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{rd, sp, p, n};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    chk("done", 8'h01, 8'(done));
    chk("bus idle", 8'h03, {6'h00, scl_w, sda_w});
    chk("drive level", 8'h00, {6'h00, m_scl_o, m_sda_o});
    chk("err", 8'(nak), 8'(err));
    if (sp && !nak) exp_ptr = p;
    if (!rd && !nak) begin
      // without a pointer byte the first data byte becomes the pointer
      foreach (sent[j]) begin
        if (j == 0 && !sp) exp_ptr = sent[j];
        else begin
          exp_mem[exp_ptr] = sent[j];
          exp_ptr++;
        end
      end
    end
    if (rd) begin
      chk("read count", exp_reads(nak, n), 8'(rxq.size()));
      foreach (rxq[j]) begin
        chk("read data", exp_mem[exp_ptr], rxq[j]);
        exp_ptr++;
      end
    end
    sent = {};
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    stretch = 1'b0;
    s_addr = 7'h68;
    n_errors = 0;
    checked = 0;
    exp_ptr = 8'h00;
    for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i * 7) ^ 8'h3c;
    void'($urandom(56629));
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    // fill the buffer until it refuses, then drain it with the slave stalling
    fill(10);
    repeat (20) @(negedge clk);
    chk("fifo full", 8'h00, 8'(wr_ready));
    chk("fifo held", 8'h02, 8'(wrq.size()));
    stretch = 1'b1;
    xfer("write wrap", 1'b0, 1'b1, 8'hf8, 8'h0a, 1'b0);
    chk("fifo empty", 8'h01, 8'(wr_ready));
    stretch = 1'b0;
    xfer("read wrap", 1'b1, 1'b1, 8'hf8, 8'h0a, 1'b0);
    xfer("read on", 1'b1, 1'b0, 8'h00, 8'h03, 1'b0);
    xfer("set pointer", 1'b0, 1'b1, 8'h40, 8'h00, 1'b0);
    xfer("single read", 1'b1, 1'b0, 8'h00, 8'h00, 1'b0);
    fill(3);
    xfer("raw write", 1'b0, 1'b0, 8'h00, 8'h03, 1'b0);
    s_addr = 7'h69;
    xfer("foreign write", 1'b0, 1'b1, 8'h10, 8'h00, 1'b1);
    xfer("foreign read", 1'b1, 1'b0, 8'h00, 8'h02, 1'b1);
    s_addr = 7'h68;
    repeat (14) begin
      cmd.rd = 1'($urandom);
      stretch = 1'($urandom);
      n_len = $urandom % 10;
      if (!cmd.rd) fill(n_len);
      xfer("random", cmd.rd, 1'($urandom), 8'($urandom), 8'(n_len), 1'b0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
